// ==== hw/ccr_can_housekeeping.sv ====
// Housekeeping logic of a CAN controller: prescaler, standby, resets, mailbox access.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Time quantum equals two times (prescale plus one) clock periods.
// - Module clock stopped after reset until enabled.
// - Hardware reset and standby initialize module except mailbox RAM.
// - Soft reset clears all but itself, standby and mailbox RAM.
// - Every reset sets reset-done flag; software clears.
// - Mailbox RAM survives reset except control field b.
// - Mailbox access stalls one to six cycles.
// - Mailbox 0 receive can start transfer engines.
module ccr_can_housekeeping
    import ccr_pkg::*;
#(
    parameter int PRESCALE_W = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave, word addressed by index.
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Receive store from the CAN engine.
    input wire logic rx_store_req,
    input wire logic [4:0] rx_store_addr,
    input wire logic [31:0] rx_store_data,
    input wire logic rx_mbox0_done,
    // Outputs to the CAN engine and transfer engines.
    output logic tq_tick,
    output logic can_clk_en,
    output logic can_init,
    output logic dma_start
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [PRESCALE_W-1:0] prescale_ff;
    logic [PRESCALE_W:0] tq_cnt_ff;
    logic [7:0] mcr_ff;
    logic [7:0] irr_ff;
    logic [7:0] imr_ff;
    logic stb_ff;
    logic [31:0] mbox_ff [CCR_MBOX_WORDS];
    logic [2:0] store_cnt_ff;
    logic [31:0] rdata_ff;
    logic ack_ff;
    logic mod_init;
    logic soft_rst;
    logic req;
    logic is_mbox;
    logic [4:0] mbox_idx;
    logic [PRESCALE_W:0] tq_last;
    logic [31:0] wmask;

    assign req = avs_read | avs_write;
    assign is_mbox = avs_address >= CCR_IDX_MBOX_BASE
        && avs_address < CCR_IDX_MBOX_BASE + 8'(CCR_MBOX_WORDS);
    assign mbox_idx = avs_address[4:0];
    // Hardware reset and standby both hold the module initialized.
    assign mod_init = stb_ff;
    assign soft_rst = mcr_ff[CCR_MCR_SOFT_RESET];
    assign can_init = mod_init | soft_rst;
    assign can_clk_en = ~stb_ff;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // Mailbox access waits while a received frame is stored; the store counter
    // caps that wait at five cycles, so the host never stalls longer than six.
    assign avs_waitrequest = req & ~ack_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else if (ack_ff) begin
            ack_ff <= 1'b0;
        end else if (req && !(is_mbox && rx_store_req
                     && store_cnt_ff < 3'(CCR_STORE_WAIT_MAX))) begin
            ack_ff <= 1'b1;
        end
    end

    // Counts how long the receive store has held off a mailbox access.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            store_cnt_ff <= 3'h0;
        end else if (req && is_mbox && rx_store_req && !ack_ff) begin
            store_cnt_ff <= store_cnt_ff + 3'h1;
        end else begin
            store_cnt_ff <= 3'h0;
        end
    end

    // ------------------------------------------------------------
    // Standby and control registers
    // ------------------------------------------------------------
    // Standby is not touched by soft reset; it belongs to the system.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stb_ff <= STB_RST;
        end else if (avs_write && ack_ff && avs_address == CCR_IDX_STANDBY) begin
            stb_ff <= avs_writedata[CCR_STB_CAN_STOP];
        end
    end

    // Outside the four sleep-safe registers only prescale writes are dropped in sleep; standby and mailbox writes still land.
    always_ff @(posedge clk) begin
        if (!rst_n || mod_init) begin
            mcr_ff <= CCR_MCR_RST;
            prescale_ff <= PRESCALE_W'(CCR_PRESCALE_RST);
            imr_ff <= CCR_IMR_RST;
        end else if (avs_write && ack_ff) begin
            if (avs_address == CCR_IDX_MASTER_CONTROL) begin
                mcr_ff <= avs_writedata[7:0];
            end else if (soft_rst) begin
                imr_ff <= CCR_IMR_RST;
                prescale_ff <= PRESCALE_W'(CCR_PRESCALE_RST);
            end else if (avs_address == CCR_IDX_INT_MASK) begin
                imr_ff <= avs_writedata[7:0];
            end else if (avs_address == CCR_IDX_PRESCALE && !mcr_ff[CCR_MCR_SLEEP]) begin
                prescale_ff <= avs_writedata[PRESCALE_W-1:0];
            end
        end else if (soft_rst) begin
            // Soft reset leaves its own bit alone so software ends it.
            mcr_ff <= (CCR_MCR_RST & ~8'h01) | {7'h00, 1'b1};
            imr_ff <= CCR_IMR_RST;
            prescale_ff <= PRESCALE_W'(CCR_PRESCALE_RST);
        end
    end

    // Reset-done is set by any reset and wins over a software clear.
    always_ff @(posedge clk) begin
        if (!rst_n || can_init) begin
            irr_ff <= 8'h01;
        end else begin
            if (avs_write && ack_ff && avs_address == CCR_IDX_INT_REQUEST) begin
                irr_ff <= irr_ff & ~avs_writedata[7:0];
            end
            if (rx_mbox0_done) begin
                irr_ff[CCR_IRR_MBOX0_RX] <= 1'b1;
            end
        end
    end
    assign dma_start = rx_mbox0_done & ~imr_ff[CCR_IRR_MBOX0_RX];

    // ------------------------------------------------------------
    // Time quantum divider
    // ------------------------------------------------------------
    // The last count of a quantum is twice the code plus one; built by concatenation
    // it fits the counter even for the top code, where a quantum is 512 periods.
    assign tq_last = {prescale_ff, 1'b1};
    always_ff @(posedge clk) begin
        if (!rst_n || can_init) begin
            tq_cnt_ff <= '0;
            tq_tick <= 1'b0;
        end else if (tq_cnt_ff == tq_last) begin
            tq_cnt_ff <= '0;
            tq_tick <= 1'b1;
        end else begin
            tq_cnt_ff <= tq_cnt_ff + 1'b1;
            tq_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Mailbox storage
    // ------------------------------------------------------------
    // Plain RAM: only the control-b word is cleared by reset.
    generate
        for (genvar i = 0; i < CCR_MBOX_WORDS; i++) begin : g_mbox
            always_ff @(posedge clk) begin
                if ((!rst_n || can_init) && 5'(i) == CCR_MBOX_CTRL_B) begin
                    mbox_ff[i] <= CCR_MBOX_CTRL_B_RST;
                end else if (rx_store_req && rx_store_addr == 5'(i)) begin
                    mbox_ff[i] <= rx_store_data;
                end else if (avs_write && ack_ff && is_mbox && mbox_idx == 5'(i)) begin
                    mbox_ff[i] <= (mbox_ff[i] & ~wmask) | (avs_writedata & wmask);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Unmapped addresses read zero; reads during sleep see only sleep-safe registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read && !ack_ff) begin
            rdata_ff <= 32'h0000_0000;
            if (avs_address == CCR_IDX_MASTER_CONTROL) begin
                rdata_ff <= {24'h0, mcr_ff};
            end else if (avs_address == CCR_IDX_GLOBAL_STATUS) begin
                rdata_ff <= {27'h0, mcr_ff[CCR_MCR_SLEEP], can_init, 3'h0};
            end else if (avs_address == CCR_IDX_INT_REQUEST) begin
                rdata_ff <= {24'h0, irr_ff};
            end else if (avs_address == CCR_IDX_INT_MASK) begin
                rdata_ff <= {24'h0, imr_ff};
            end else if (mcr_ff[CCR_MCR_SLEEP]) begin
                rdata_ff <= 32'h0000_0000;
            end else if (avs_address == CCR_IDX_PRESCALE) begin
                rdata_ff <= 32'(prescale_ff);
            end else if (avs_address == CCR_IDX_STANDBY) begin
                rdata_ff <= {31'h0, stb_ff};
            end else if (is_mbox) begin
                rdata_ff <= mbox_ff[mbox_idx];
            end
        end
    end
    assign avs_readdata = rdata_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Measures the spacing of quantum ticks; a prescale change or an initialization
    // voids the period in flight, because its length is then a mix of two codes.
    logic [PRESCALE_W+1:0] chk_gap_ff;
    logic [PRESCALE_W-1:0] chk_p_ff;
    logic chk_valid_ff;
    always_ff @(posedge clk) begin
        chk_p_ff <= prescale_ff;
        if (!rst_n || can_init || prescale_ff != chk_p_ff) begin
            chk_gap_ff <= '0;
            chk_valid_ff <= 1'b0;
        end else if (tq_tick) begin
            chk_gap_ff <= (PRESCALE_W+2)'(1);
            chk_valid_ff <= 1'b1;
        end else begin
            chk_gap_ff <= chk_gap_ff + 1'b1;
        end
    end
    property p_tq_len;
        @(posedge clk) disable iff (!rst_n)
        tq_tick && chk_valid_ff |->
            chk_gap_ff == {({1'b0, chk_p_ff} + (PRESCALE_W+1)'(1)), 1'b0};
    endproperty
    a_tq_len: assert property (p_tq_len) else $error("quantum length wrong");
    // Checked straight out of reset, so this one is not disabled by the reset.
    property p_stb_stop;
        @(posedge clk)
        !rst_n |=> !can_clk_en && can_init;
    endproperty
    a_stb_stop: assert property (p_stb_stop) else $error("clock runs in standby");
    property p_tq_quiet;
        @(posedge clk) disable iff (!rst_n)
        !can_clk_en |=> !tq_tick;
    endproperty
    a_tq_quiet: assert property (p_tq_quiet) else $error("quantum ticks while stopped");
    property p_init_mcr;
        @(posedge clk) disable iff (!rst_n)
        mod_init |=> mcr_ff == CCR_MCR_RST;
    endproperty
    a_init_mcr: assert property (p_init_mcr) else $error("standby did not initialize");
    property p_soft_keep;
        @(posedge clk) disable iff (!rst_n)
        soft_rst && !mod_init && !(avs_write && ack_ff) |=> soft_rst && imr_ff == CCR_IMR_RST;
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("soft reset lost");
    property p_rst_done;
        @(posedge clk) disable iff (!rst_n)
        can_init |=> irr_ff[CCR_IRR_RESET_DONE];
    endproperty
    a_rst_done: assert property (p_rst_done) else $error("reset-done not set");
    property p_wait_max;
        @(posedge clk) disable iff (!rst_n)
        req && !ack_ff |-> ##[1:6] ack_ff;
    endproperty
    a_wait_max: assert property (p_wait_max) else $error("mailbox wait too long");
    property p_dma;
        @(posedge clk) disable iff (!rst_n)
        dma_start |-> rx_mbox0_done && !imr_ff[CCR_IRR_MBOX0_RX];
    endproperty
    a_dma: assert property (p_dma) else $error("spurious transfer start");
    property p_mbox0_flag;
        @(posedge clk) disable iff (!rst_n)
        rx_mbox0_done && !can_init |=> irr_ff[CCR_IRR_MBOX0_RX];
    endproperty
    a_mbox0_flag: assert property (p_mbox0_flag) else $error("mailbox 0 flag lost");
    property p_ctrlb;
        @(posedge clk) disable iff (!rst_n)
        can_init && !rx_store_req |=> mbox_ff[CCR_MBOX_CTRL_B] == CCR_MBOX_CTRL_B_RST;
    endproperty
    a_ctrlb: assert property (p_ctrlb) else $error("control b not cleared");
endmodule // ccr_can_housekeeping
`default_nettype wire

// ==== inc/ccr_pkg.sv ====
// Package with the register map, field positions and constants of the CAN housekeeping block.
package ccr_pkg;
    // ------------------------------------------------------------
    // Register word indexes
    // ------------------------------------------------------------
    // The printed offset 0x006 is not a multiple of four, so it is an index.
    localparam logic [7:0] CCR_IDX_MASTER_CONTROL = 8'h00;
    localparam logic [7:0] CCR_IDX_GLOBAL_STATUS = 8'h01;
    localparam logic [7:0] CCR_IDX_INT_REQUEST = 8'h02;
    localparam logic [7:0] CCR_IDX_INT_MASK = 8'h03;
    localparam logic [7:0] CCR_IDX_PRESCALE = 8'h06;
    localparam logic [7:0] CCR_IDX_STANDBY = 8'h08;
    localparam logic [7:0] CCR_IDX_MBOX_BASE = 8'h40;
    localparam int CCR_MBOX_WORDS = 32;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CCR_MCR_SOFT_RESET = 0;
    localparam int CCR_MCR_SLEEP = 5;
    localparam int CCR_MCR_CONFIG = 7;
    localparam int CCR_IRR_RESET_DONE = 0;
    localparam int CCR_IRR_MBOX0_RX = 1;
    localparam int CCR_GSR_RESET_STATE = 3;
    localparam int CCR_GSR_SLEEP = 4;
    localparam int CCR_STB_CAN_STOP = 0;
    // Mailbox word that plays the part of message control field b.
    localparam logic [4:0] CCR_MBOX_CTRL_B = 5'h01;
    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] CCR_PRESCALE_RST = 8'h00;
    localparam logic [7:0] CCR_MCR_RST = 8'h81;
    localparam logic [7:0] CCR_IMR_RST = 8'hFF;
    localparam logic STB_RST = 1'b1;
    localparam int CCR_STORE_WAIT_MAX = 5;
    localparam logic [31:0] CCR_MBOX_CTRL_B_RST = 32'h0000_0000;
endpackage

// ==== tb/ccr_can_node_model.sv ====
// Behavioural CAN node that stores one received frame into the mailbox RAM.
`timescale 1ns/1ps
`default_nettype none
module ccr_can_node_model (
    // Clock, reset and trigger from the bench.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic frame_go,
    input wire logic [31:0] frame_base,
    // Receive store towards the block.
    output logic rx_store_req,
    output logic [4:0] rx_store_addr,
    output logic [31:0] rx_store_data,
    output logic rx_mbox0_done
);
    logic [2:0] step_ff;
    // Steps one to four store words 0x10 to 0x13, step five flags mailbox 0 done.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            step_ff <= 3'h0;
        end else if (step_ff != 3'h0) begin
            step_ff <= (step_ff == 3'h5) ? 3'h0 : step_ff + 3'h1;
        end else if (frame_go) begin
            step_ff <= 3'h1;
        end
    end
    // Idle lines show inverted data so the block cannot lean on a stale word.
    assign rx_store_req = (step_ff >= 3'h1) && (step_ff <= 3'h4);
    assign rx_store_addr = {2'h2, step_ff - 3'h1};
    assign rx_store_data = rx_store_req ? frame_base + {29'h0, step_ff} : ~frame_base;
    assign rx_mbox0_done = (step_ff == 3'h5);
endmodule // ccr_can_node_model
`default_nettype wire

// ==== tb/tb_ccr_can_housekeeping.sv ====
// Self-checking testbench of the CAN housekeeping block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_ccr_can_housekeeping;
    import ccr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, rx_store_data, q, m0;
    logic avs_waitrequest, rx_store_req, rx_mbox0_done, tq_tick, can_clk_en, can_init, dma_start;
    logic [4:0] rx_store_addr;
    logic frame_go = 1'b0;
    logic imr_b1 = 1'b1;
    logic [31:0] frame_base = 32'h0;
    logic [7:0] p;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int w, n;
    ccr_can_housekeeping #(.PRESCALE_W(8)) u_ccr_can_housekeeping (.clk(clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_store_req(rx_store_req), .rx_store_addr(rx_store_addr),
        .rx_store_data(rx_store_data), .rx_mbox0_done(rx_mbox0_done), .tq_tick(tq_tick),
        .can_clk_en(can_clk_en), .can_init(can_init), .dma_start(dma_start));
    ccr_can_node_model u_ccr_can_node_model (.clk(clk), .rst_n(rst_n), .frame_go(frame_go),
        .frame_base(frame_base), .rx_store_req(rx_store_req), .rx_store_addr(rx_store_addr),
        .rx_store_data(rx_store_data), .rx_mbox0_done(rx_mbox0_done));
    // ------------------------------------------------------------
    // Clock, timeout and helpers.
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    // A hung handshake would stall the run forever, so cap it well above the expected length.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    // Every mailbox 0 done pulse must start the engine only while its mask bit is clear.
    always @(posedge clk) begin
        if (rx_mbox0_done === 1'b1) `CHK(dma_start, ~imr_b1)
    end
    function automatic int exp_tq(input logic [7:0] v);
        return 2 * (int'(v) + 1);
    endfunction
    task automatic final_report();
        if (err_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One bus cycle held until waitrequest is sampled low; w counts the stalled edges.
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        w = 0;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            w++;
            @(posedge clk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Counts edges between two quantum ticks.
    task automatic tq_gap();
        do @(posedge clk); while (tq_tick !== 1'b1);
        n = 0;
        do begin
            n++;
            @(posedge clk);
        end while (tq_tick !== 1'b1);
    endtask
    // Main sequence; the hardware reset after the soft reset scenario covers retention of mailbox RAM.
    initial begin
        void'($urandom(32'hed9408d3));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        `CHK(can_clk_en, 1'b0)
        `CHK(can_init, 1'b1)
        acc(1'b0, CCR_IDX_PRESCALE, 32'h0);
        `CHK(q[7:0], CCR_PRESCALE_RST)
        acc(1'b0, CCR_IDX_INT_REQUEST, 32'h0);
        `CHK(q[CCR_IRR_RESET_DONE], 1'b1)
        acc(1'b1, CCR_IDX_INT_REQUEST, 32'h1);
        acc(1'b1, CCR_IDX_STANDBY, 32'h0);
        // Configuration mode without soft reset: software clears reset-done here.
        acc(1'b1, CCR_IDX_MASTER_CONTROL, 32'h80);
        acc(1'b1, CCR_IDX_INT_REQUEST, 32'h1);
        acc(1'b0, CCR_IDX_INT_REQUEST, 32'h0);
        `CHK(q[CCR_IRR_RESET_DONE], 1'b0)
        acc(1'b1, CCR_IDX_MASTER_CONTROL, 32'h0);
        @(posedge clk);
        `CHK(can_clk_en, 1'b1)
        `CHK(can_init, 1'b0)
        for (int i = 0; i < 6; i++) begin
            p = (i < 3) ? 8'(i) : (i == 3) ? 8'hFF : 8'($urandom_range(40, 3));
            acc(1'b1, CCR_IDX_PRESCALE, {24'h0, p});
            tq_gap();
            tq_gap();
            `CHK(n, exp_tq(p))
        end
        m0 = $urandom;
        acc(1'b1, CCR_IDX_MBOX_BASE, m0);
        acc(1'b1, CCR_IDX_MBOX_BASE + 8'h01, ~m0);
        acc(1'b1, CCR_IDX_MASTER_CONTROL, 32'h1);
        @(posedge clk);
        `CHK(can_init, 1'b1)
        `CHK(can_clk_en, 1'b1)
        acc(1'b0, CCR_IDX_MASTER_CONTROL, 32'h0);
        `CHK(q[CCR_MCR_SOFT_RESET], 1'b1)
        acc(1'b0, CCR_IDX_PRESCALE, 32'h0);
        `CHK(q[7:0], CCR_PRESCALE_RST)
        acc(1'b0, CCR_IDX_INT_REQUEST, 32'h0);
        `CHK(q[CCR_IRR_RESET_DONE], 1'b1)
        acc(1'b0, CCR_IDX_MBOX_BASE + 8'h01, 32'h0);
        `CHK(q, CCR_MBOX_CTRL_B_RST)
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        `CHK(can_clk_en, 1'b0)
        acc(1'b0, CCR_IDX_MBOX_BASE, 32'h0);
        `CHK(q, m0)
        acc(1'b1, CCR_IDX_STANDBY, 32'h0);
        acc(1'b1, CCR_IDX_MASTER_CONTROL, 32'h0);
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, CCR_IDX_INT_MASK, (k == 0) ? 32'hFF : 32'hFD);
            imr_b1 <= (k == 0);
            frame_base <= $urandom;
            frame_go <= 1'b1;
            @(posedge clk);
            frame_go <= 1'b0;
            acc(1'b0, CCR_IDX_MBOX_BASE, 32'h0);
            `CHK(w <= 6, 1'b1)
            repeat (8) @(posedge clk);
            acc(1'b0, CCR_IDX_MBOX_BASE + 8'h10, 32'h0);
            `CHK(q, frame_base + 32'h1)
        end
        // Only master control and global status, two of the four sleep-safe registers, are touched while asleep.
        acc(1'b1, CCR_IDX_MASTER_CONTROL, 32'h20);
        acc(1'b0, CCR_IDX_GLOBAL_STATUS, 32'h0);
        `CHK(q[CCR_GSR_SLEEP], 1'b1)
        acc(1'b1, CCR_IDX_MASTER_CONTROL, 32'h0);
        acc(1'b0, 8'h3F, 32'h0);
        `CHK(q, 32'h0)
        acc(1'b1, CCR_IDX_STANDBY, 32'h1);
        @(posedge clk);
        `CHK(can_init, 1'b1)
        final_report();
    end
endmodule // tb_ccr_can_housekeeping
`default_nettype wire
